// ### logic/initial_reset_controller.sv
/*
 * Initial reset controller: merges power-on, reset pin and input port
 * coincidence into one initial reset and supplies the CPU start values.
 * Assumes RST_N is the power-on detector output, and that the oscillator
 * status, reset pin and input port pins are asynchronous to CLK_SYS.
 */
// The implementer's own choices: the Avalon-MM slave port and the address map.
module initial_reset_controller #(
    parameter reset_ctl_pkg::coin_sel_t COIN_SEL =
        reset_ctl_pkg::SEL_PINS_0123,
    parameter int unsigned FILTER_CYCLES = reset_ctl_pkg::FILTER_CYCLES
) (
    input  wire logic                     CLK_SYS,
    input  wire logic                     RST_N,
    input  wire logic                     OSC_RUNNING,
    input  wire logic                     RESET_PIN,
    input  wire logic [3:0]               INPUT_PORT_PINS,
    output logic                          INITIAL_RESET,
    output reset_ctl_pkg::cpu_init_t      CPU_INIT,
    input  wire logic [3:0]               AVS_ADDRESS,
    input  wire logic                     AVS_READ,
    input  wire logic                     AVS_WRITE,
    input  wire logic [31:0]              AVS_WRITEDATA,
    input  wire logic [3:0]               AVS_BYTEENABLE,
    output logic [31:0]                   AVS_READDATA,
    output logic                          AVS_WAITREQUEST
);

    // =========================================================================
    // Functions
    // =========================================================================

    // Pins that take part in the coincidence for each build option.
    function automatic logic [3:0] sel_mask(
        input reset_ctl_pkg::coin_sel_t sel
    );
        logic [3:0] m;
        m = 4'h0;
        case (sel)
            reset_ctl_pkg::SEL_PINS_01:   m = 4'h3;
            reset_ctl_pkg::SEL_PINS_012:  m = 4'h7;
            reset_ctl_pkg::SEL_PINS_0123: m = 4'hf;
            default:                      m = 4'h0;
        endcase
        return m;
    endfunction : sel_mask

    // Byte-lane merge of a bus write into a 32-bit register.
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_value,
        input logic [31:0] new_value,
        input logic [3:0]  lanes
    );
        logic [31:0] r;
        r = old_value;
        for (int i = 0; i < 4; i++) begin
            if (lanes[i]) begin
                r[8*i +: 8] = new_value[8*i +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    // =========================================================================
    // Input synchronisers
    // =========================================================================
    logic [5:0] sync_meta;
    logic [5:0] sync_out;
    wire  logic       osc_run_s = sync_out[5];
    wire  logic       pin_s     = sync_out[4];
    wire  logic [3:0] kport_s   = sync_out[3:0];

    // Two flops per pin; only the second stage feeds any logic.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            sync_meta <= 6'h00;
            sync_out  <= 6'h00;
        end else begin
            sync_meta <= {OSC_RUNNING, RESET_PIN, INPUT_PORT_PINS};
            sync_out  <= sync_meta;
        end
    end

    // =========================================================================
    // Power-on hold
    // =========================================================================
    logic por_active;

    // Set by the power-on detector, cleared once the oscillator is seen.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            por_active <= 1'b1;
        end else if (osc_run_s) begin
            por_active <= 1'b0;
        end
    end

    // =========================================================================
    // Coincidence filter
    // =========================================================================
    localparam logic [3:0] COIN_MASK = sel_mask(COIN_SEL);

    logic [31:0] filter_limit;
    logic [31:0] filter_count;
    wire  logic        coin_enabled = (COIN_MASK != 4'h0);
    wire  logic        coin_high    =
        coin_enabled && ((kport_s & COIN_MASK) == COIN_MASK);
    wire  logic        coin_hit     =
        coin_high && (filter_count >= filter_limit);
    wire  logic [31:0] next_filter_count =
        !coin_high ? 32'h0000_0000 :
        coin_hit   ? filter_count :
                     filter_count + 32'h0000_0001;

    // The count saturates at the limit so a long press never wraps.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            filter_count <= 32'h0000_0000;
        end else begin
            filter_count <= next_filter_count;
        end
    end

    // =========================================================================
    // Initial reset and CPU start values
    // =========================================================================
    wire logic next_initial_reset =
        por_active || pin_s || coin_hit;

    // Reset is asserted from the power-on edge itself, not a cycle later.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            INITIAL_RESET <= 1'b1;
        end else begin
            INITIAL_RESET <= next_initial_reset;
        end
    end

    // The CPU copies these while INITIAL_RESET is high; other CPU state
    // is left to whatever it held, so nothing else is offered.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            // All zero while the power-on detector holds the block; the
            // start values appear from the first clock after release.
            CPU_INIT <= '0;
        end else begin
            CPU_INIT <= '{program_step_counter: reset_ctl_pkg::STEP_INIT,
                          program_page_counter: reset_ctl_pkg::PAGE_INIT,
                          new_page_pointer:     reset_ctl_pkg::NEW_PAGE_INIT,
                          interrupt_flag:       reset_ctl_pkg::IFLAG_INIT,
                          decimal_flag:         reset_ctl_pkg::DFLAG_INIT};
        end
    end

    // =========================================================================
    // Register bus slave
    // =========================================================================
    logic        bus_ack;
    logic [2:0]  cause;
    wire  logic  bus_req    = AVS_READ || AVS_WRITE;
    wire  logic  hit_limit  =
        (AVS_ADDRESS == reset_ctl_pkg::OFS_FILTER_LIMIT);
    wire  logic  hit_status = (AVS_ADDRESS == reset_ctl_pkg::OFS_STATUS);
    wire  logic  hit_cause  = (AVS_ADDRESS == reset_ctl_pkg::OFS_CAUSE);
    wire  logic  hit_count  =
        (AVS_ADDRESS == reset_ctl_pkg::OFS_FILTER_COUNT);
    wire  logic  wr_done    = AVS_WRITE && bus_ack;
    wire  logic [2:0] cause_set  = {coin_hit, pin_s, por_active};
    wire  logic [2:0] cause_clr  =
        (wr_done && hit_cause && AVS_BYTEENABLE[0]) ?
        AVS_WRITEDATA[2:0] : 3'h0;
    wire  logic [31:0] status_word = {26'h0, COIN_SEL,
        coin_hit, pin_s, por_active, INITIAL_RESET};
    wire  logic [31:0] read_mux =
        hit_limit  ? filter_limit :
        hit_status ? status_word :
        hit_cause  ? {29'h0, cause} :
        hit_count  ? filter_count : 32'h0000_0000;

    // One wait state: the request is seen, then answered on the next edge.
    assign AVS_WAITREQUEST = bus_req && !bus_ack;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            bus_ack      <= 1'b0;
            AVS_READDATA <= 32'h0000_0000;
        end else begin
            bus_ack      <= bus_req && !bus_ack;
            if (AVS_READ && !bus_ack) begin
                AVS_READDATA <= read_mux;
            end
        end
    end

    // Filter limit is writable so a bench or trim can shorten the time.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            filter_limit <= FILTER_CYCLES;
        end else if (wr_done && hit_limit) begin
            filter_limit <= merge_bytes(filter_limit, AVS_WRITEDATA,
                                        AVS_BYTEENABLE);
        end
    end

    // Sticky causes, write one to clear; a new event beats the clear.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            cause <= reset_ctl_pkg::CAUSE_RESET_VALUE;
        end else begin
            cause <= (cause & ~cause_clr) | cause_set;
        end
    end

endmodule : initial_reset_controller

// ### logic/reset_ctl_pkg.sv
/*
 * Constants and types for the initial reset controller: register offsets,
 * field positions, reset values, CPU start values and filter timing.
 * Assumes a 100 MHz system clock and a 32-bit register bus.
 */
package reset_ctl_pkg;

    // =========================================================================
    // Clock and filter timing
    // =========================================================================
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned FILTER_TIME_MS  = 1000;
    // Tolerance of the filter time in percent, kept for reference only.
    localparam int unsigned FILTER_TOL_PCT  = 5;
    localparam int unsigned FILTER_CYCLES   =
        FILTER_TIME_MS * (CLK_HZ / 1000);

    // =========================================================================
    // Register offsets (byte addresses, one aligned word each)
    // =========================================================================
    localparam logic [3:0] OFS_FILTER_LIMIT = 4'h0;
    localparam logic [3:0] OFS_STATUS       = 4'h4;
    localparam logic [3:0] OFS_CAUSE        = 4'h8;
    localparam logic [3:0] OFS_FILTER_COUNT = 4'hc;

    // =========================================================================
    // Field positions of the status register and reset value of the cause register
    // =========================================================================
    localparam int unsigned BIT_RESET_ACTIVE = 0;
    localparam int unsigned BIT_POWER_ON     = 1;
    localparam int unsigned BIT_RESET_PIN    = 2;
    localparam int unsigned BIT_COINCIDENCE  = 3;
    localparam int unsigned POS_OPTION       = 4;
    localparam logic [2:0] CAUSE_RESET_VALUE = 3'h0;

    // =========================================================================
    // CPU start values loaded during initial reset
    // =========================================================================
    localparam logic [7:0] STEP_INIT     = 8'h00;
    localparam logic [3:0] PAGE_INIT     = 4'h1;
    localparam logic [3:0] NEW_PAGE_INIT = 4'h1;
    localparam logic       IFLAG_INIT    = 1'h0;
    localparam logic       DFLAG_INIT    = 1'h0;

    // Pin group watched by the coincidence detector.
    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_PINS_01,
        SEL_PINS_012,
        SEL_PINS_0123
    } coin_sel_t;

    // Start values the CPU takes while initial reset is active.
    typedef struct packed {
        logic [7:0] program_step_counter;
        logic [3:0] program_page_counter;
        logic [3:0] new_page_pointer;
        logic       interrupt_flag;
        logic       decimal_flag;
    } cpu_init_t;

endpackage : reset_ctl_pkg

// ### verif/board_reset_source.sv
/* Board-side reset source: drives the reset pin and input port pins.
   Assumes the bench commands it on the rising clock edge. */
module board_reset_source (
    input  wire logic       clk,
    input  wire logic       pin_cmd,
    input  wire logic [3:0] port_cmd,
    output logic            reset_pin = 1'b0,
    output logic [3:0]      port_pins = 4'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pins follow one edge late; all pins high only when a reset is meant.
    always @(posedge clk) begin
        reset_pin <= pin_cmd;
        port_pins <= port_cmd;
    end
endmodule : board_reset_source

// ### verif/initial_reset_controller_tb_top.sv
/* Self-checking bench for the initial reset controller.
   Assumes the board model beside it and the bound port checker. */
module initial_reset_controller_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // A short filter keeps the run brief; expectations derive from it.
    localparam int unsigned FILT = 20;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        osc = 1'b0;
    logic        pin_cmd = 1'b0;
    logic [3:0]  port_cmd = 4'h0;
    logic [3:0]  adr = 4'h0;
    logic        rd = 1'b0;
    logic        we = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, q;
    logic [3:0]  port_pins;
    logic        reset_pin, init_rst, wait_req;
    reset_ctl_pkg::cpu_init_t cpu_init;
    int          failures = 0;
    int          check_count = 0;
    always #5 clk = ~clk;
    board_reset_source board_reset_source_inst (.clk(clk), .pin_cmd(pin_cmd),
        .port_cmd(port_cmd), .reset_pin(reset_pin), .port_pins(port_pins));
    initial_reset_controller #(.FILTER_CYCLES(FILT))
        initial_reset_controller_inst (.CLK_SYS(clk), .RST_N(rst_n),
        .OSC_RUNNING(osc), .RESET_PIN(reset_pin), .INPUT_PORT_PINS(port_pins),
        .INITIAL_RESET(init_rst), .CPU_INIT(cpu_init), .AVS_ADDRESS(adr),
        .AVS_READ(rd), .AVS_WRITE(we), .AVS_WRITEDATA(wdat),
        .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wait_req));
    // ==================================================================
    // Shared tasks
    // ==================================================================
    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input string nm, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    // Request held until waitrequest is sampled low; bounded wait.
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        adr <= a;
        wdat <= d;
        rd <= !wr;
        we <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (wait_req !== 1'b0 && n < 40);
        q = rdat;
        rd <= 1'b0;
        we <= 1'b0;
        check("bus answer", wait_req, 1'b0);
        if (wait_req !== 1'b0) wrap_up();
    endtask : bus
    task automatic wait_rst(input logic v, input int lim);
        int n = 0;
        while (init_rst !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        check("initial reset", init_rst, v);
        if (init_rst !== v) wrap_up();
    endtask : wait_rst
    // ==================================================================
    // Scenarios
    // ==================================================================
    task automatic t_power;
        repeat (8) @(posedge clk);
        check("held before osc", init_rst, 1'b1);
        check("cpu start values", cpu_init, 18'h00044);
        bus(1'b0, 4'h0, 32'h0);
        check("limit reset value", q, FILT);
        osc <= 1'b1;
        wait_rst(1'b0, 10);
        bus(1'b0, 4'h8, 32'h0);
        check("power-on cause", q, 32'h1);
        bus(1'b1, 4'h8, 32'h1);
        bus(1'b0, 4'h8, 32'h0);
        check("cause cleared", q, 32'h0);
        bus(1'b0, 4'h1, 32'h0);
        check("unmapped read", q, 32'h0);
        $display("Power-on test done");
    endtask : t_power
    task automatic t_pin;
        pin_cmd <= 1'b1;
        wait_rst(1'b1, 8);
        bus(1'b0, 4'h4, 32'h0);
        check("status in pin reset", q, 32'h35);
        pin_cmd <= 1'b0;
        wait_rst(1'b0, 8);
        $display("Reset pin test done");
    endtask : t_pin
    // A one-cycle drop must restart the filter; a subset never counts.
    task automatic t_coin;
        port_cmd <= 4'h7;
        repeat (40) @(posedge clk);
        check("subset of pins", init_rst, 1'b0);
        port_cmd <= 4'hf;
        repeat (10) @(posedge clk);
        port_cmd <= 4'hb;
        @(posedge clk);
        port_cmd <= 4'hf;
        repeat (FILT) @(posedge clk);
        check("filter restart", init_rst, 1'b0);
        wait_rst(1'b1, 10);
        // The count must rest at the limit while the pins stay high.
        bus(1'b0, 4'hc, 32'h0);
        check("count saturates", q, FILT);
        bus(1'b0, 4'h8, 32'h0);
        check("causes", q, 32'h6);
        port_cmd <= 4'h0;
        wait_rst(1'b0, 8);
        bus(1'b1, 4'h0, 32'h8);
        bus(1'b0, 4'h0, 32'h0);
        check("limit written", q, 32'h8);
        $display("Coincidence test done");
    endtask : t_coin
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_power();
        t_pin();
        t_coin();
        wrap_up();
    end
endmodule : initial_reset_controller_tb_top

// ### verif/reset_ctl_checker.sv
/* Port checker for the initial reset controller.
   Assumes one clock domain; bound to the design top below. */
module reset_ctl_checker #(
    parameter reset_ctl_pkg::coin_sel_t COIN_SEL = reset_ctl_pkg::SEL_NONE,
    parameter int unsigned FILTER_CYCLES = 20
) (
    input wire logic                     CLK_SYS,
    input wire logic                     RST_N,
    input wire logic                     OSC_RUNNING,
    input wire logic                     RESET_PIN,
    input wire logic [3:0]               INPUT_PORT_PINS,
    input wire logic                     INITIAL_RESET,
    input wire reset_ctl_pkg::cpu_init_t CPU_INIT,
    input wire logic                     AVS_READ,
    input wire logic                     AVS_WRITE,
    input wire logic                     AVS_WAITREQUEST
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==================================================================
    // Helper logic and properties
    // ==================================================================
    // Watched pins; an empty mask means the detector can never fire.
    wire logic [3:0] sel_mask = {COIN_SEL == reset_ctl_pkg::SEL_PINS_0123,
        COIN_SEL >= reset_ctl_pkg::SEL_PINS_012,
        {2{COIN_SEL != reset_ctl_pkg::SEL_NONE}}};
    wire logic all_hi = (sel_mask != 4'h0) &&
        ((INPUT_PORT_PINS & sel_mask) == sel_mask);
    wire logic req = AVS_READ || AVS_WRITE;
    int unsigned hi_run;
    // Run length of the selected pins all high; any drop restarts it.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            hi_run <= 0;
        end else begin
            hi_run <= all_hi ? hi_run + 1 : 0;
        end
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    sequence quiet_s;
        (!RESET_PIN && OSC_RUNNING && !all_hi)[*5];
    endsequence
    sequence waiting_s;
        req && AVS_WAITREQUEST ##1 req;
    endsequence
    a_pin_raises:
        assert property (RESET_PIN |-> ##3 INITIAL_RESET)
        else $error("pin reset not seen in time");
    a_power_hold:
        assert property ($rose(RST_N) |-> INITIAL_RESET[*4])
        else $error("power-on hold too short");
    a_cpu_values:
        assert property (INITIAL_RESET && $past(RST_N) |->
            CPU_INIT == 18'h00044) else $error("wrong cpu start values");
    a_quiet_release:
        assert property (quiet_s |-> !INITIAL_RESET)
        else $error("reset held with no source");
    a_coin_fires:
        assert property (hi_run >= FILTER_CYCLES + 4 |-> INITIAL_RESET)
        else $error("coincidence reset missing");
    a_one_wait: assert property (waiting_s |-> !AVS_WAITREQUEST)
        else $error("bus answer late");
    a_new_access: assert property (req && !AVS_WAITREQUEST ##1 req
        |-> AVS_WAITREQUEST) else $error("access without wait state");
    a_idle_ready: assert property (!req |-> !AVS_WAITREQUEST)
        else $error("wait raised while idle");
endmodule : reset_ctl_checker
bind initial_reset_controller reset_ctl_checker #(.COIN_SEL(COIN_SEL),
    .FILTER_CYCLES(FILTER_CYCLES)) reset_ctl_checker_inst (.CLK_SYS(CLK_SYS),
    .RST_N(RST_N), .OSC_RUNNING(OSC_RUNNING), .RESET_PIN(RESET_PIN),
    .INPUT_PORT_PINS(INPUT_PORT_PINS), .INITIAL_RESET(INITIAL_RESET),
    .CPU_INIT(CPU_INIT), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WAITREQUEST(AVS_WAITREQUEST));
